// File: hw/dmdp_pkg.sv
// dmdp_pkg: shared constants and types for the dimming mode detect / duty reference link
package dmdp_pkg;
   // ****************************************
   // timebase
   // ****************************************
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned CLK_NS = 50;
   // ****************************************
   // timing figures, as printed, and derived cycle counts
   // ****************************************
   localparam int unsigned DETECT_DELAY_US = 100;    // one_wire_detect_delay
   localparam int unsigned LOW_QUALIFY_US = 260;     // one_wire_low_qualify_time
   localparam int unsigned DETECT_WINDOW_US = 1000;  // one_wire_detect_window, 1 msec
   localparam int unsigned SHUTDOWN_LOW_US = 2500;   // 2.5 ms low means shutdown
   localparam int unsigned PWM_MIN_HZ = 5000;
   localparam int unsigned PWM_MAX_HZ = 100000;
   // least times round up, longest round down
   localparam int unsigned DETECT_DELAY_CYC = (DETECT_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned LOW_QUALIFY_CYC = (LOW_QUALIFY_US * 1000) / CLK_NS + 1; // strictly longer
   localparam int unsigned DETECT_WINDOW_CYC = (DETECT_WINDOW_US * 1000) / CLK_NS;
   localparam int unsigned SHUTDOWN_LOW_CYC = (SHUTDOWN_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
   // host side period of pwm limits
   localparam int unsigned PWM_MAX_PERIOD_CYC = CLK_HZ / PWM_MIN_HZ;
   localparam int unsigned PWM_MIN_PERIOD_CYC = CLK_HZ / PWM_MAX_HZ;
   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int unsigned CNT_W = 17;
   localparam int unsigned REF_W = 10;
   localparam logic [REF_W-1:0] REF_FULL = 10'h3ff;  // code for 200 mV full scale
   localparam logic [4:0] STEP_DEFAULT = 5'h1f;      // stored one-wire step after power-up
   localparam int unsigned FULL_MV = 200;
   localparam int unsigned SYNC_STAGES = 2;
   typedef enum logic [1:0] {DMDP_MODE_OFF, DMDP_MODE_DUTY, DMDP_MODE_WIRE} dmdp_mode_t;
endpackage : dmdp_pkg

// File: hw/dmdp_if.sv
// dmdp_if: the single control pin between host and device
`timescale 1ns/10ps
`default_nettype none
interface dmdp_if;
   logic ctrl_out; // host drive level
   logic ctrl_oe;  // host drives pin
   logic ctrl_pin; // resolved level, pulled low when undriven
   assign ctrl_pin = ctrl_oe ? ctrl_out : 1'b0;
   modport host (output ctrl_out, output ctrl_oe);
   modport device (input ctrl_pin);
endinterface : dmdp_if
`default_nettype wire

// File: hw/dmdp_device.sv
// dmdp_device: mode detection, shutdown detection and duty-to-reference conversion
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - mode chosen anew every start, duty default
// - first rise enables, opens 1 ms window
// - wait 100 us, then low over 260 us
// - low qualified before window end, else duty
// - switch to one-wire immediately when qualified
// - mode held; 2.5 ms low shuts down
// - steady high gives full-scale reference
// - reference equals duty times full scale
// - reference depends on timing only
// - host pwm between 5 and 100 kHz
// - host drives clean logic levels
// - stored step defaults to full scale
// - stored step survives shutdown, cleared by reset
module dmdp_device
   import dmdp_pkg::*;
(
   // clock and power-up reset
   input wire logic clk,
   input wire logic srst,
   // link
   dmdp_if.device link,
   // one-wire decoder side: step write
   input wire logic step_we,
   input wire logic [4:0] step_wdata,
   // status
   output logic enabled,
   output logic one_wire_mode,
   output logic wire_entry,
   output logic [4:0] step_reg_out,
   // feedback_node reference code, full scale = 200 mV
   output logic [dmdp_pkg::REF_W-1:0] feedback_node_ref,
   output logic ref_valid
);
   import dmdp_pkg::*;

   // ****************************************
   // pin synchroniser and edges
   // ****************************************
   logic sync1_reg, sync2_reg, prev_reg;
   wire logic pin = sync2_reg;
   wire logic rise = pin & ~prev_reg;
   wire logic fall = ~pin & prev_reg;

   // two flops before use
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         sync1_reg <= link.ctrl_pin;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // saturating increment, used by all counters
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
   endfunction : sat_inc

   // ****************************************
   // mode state machine
   // ****************************************
   typedef enum logic [1:0] {DMDP_ST_OFF, DMDP_ST_DETECT, DMDP_ST_DUTY, DMDP_ST_WIRE} dmdp_state_t;
   dmdp_state_t state_reg, state_next;
   logic [CNT_W-1:0] win_reg, low_reg, sd_reg;
   logic seen_low_reg; // low phase started after detection delay

   wire logic win_open = win_reg < CNT_W'(DETECT_WINDOW_CYC);
   wire logic past_delay = win_reg >= CNT_W'(DETECT_DELAY_CYC);
   wire logic qualified = seen_low_reg & ~pin & (low_reg >= CNT_W'(LOW_QUALIFY_CYC) - 1'b1);
   wire logic shutdown = ~pin & (sd_reg >= CNT_W'(SHUTDOWN_LOW_CYC) - 1'b1);

   // next-state selection
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DMDP_ST_OFF: if (rise) state_next = DMDP_ST_DETECT;
         DMDP_ST_DETECT: begin
            if (qualified && win_open) state_next = DMDP_ST_WIRE;
            else if (!win_open) state_next = DMDP_ST_DUTY;
         end
         default: ; // mode held
      endcase
      if (state_reg != DMDP_ST_OFF && shutdown) state_next = DMDP_ST_OFF;
   end

   // window, low and shutdown timers
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= DMDP_ST_OFF;
         win_reg <= '0;
         low_reg <= '0;
         sd_reg <= '0;
         seen_low_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         win_reg <= (state_reg == DMDP_ST_OFF) ? '0 : sat_inc(win_reg);
         sd_reg <= pin ? '0 : sat_inc(sd_reg);
         low_reg <= pin ? '0 : sat_inc(low_reg);
         if (state_reg == DMDP_ST_OFF) seen_low_reg <= 1'b0;
         else if (fall) seen_low_reg <= past_delay; // low must begin after the delay
      end
   end

   // ****************************************
   // duty measurement
   // ****************************************
   logic [CNT_W-1:0] hi_reg, per_reg;
   logic [REF_W-1:0] ref_reg;
   logic valid_reg;
   wire logic duty_on = (state_reg == DMDP_ST_DUTY) || (state_reg == DMDP_ST_DETECT);
   // ratio of high time to period, scaled to full code; timing only
   wire logic [CNT_W+REF_W-1:0] prod = {{REF_W{1'b0}}, hi_reg} * (CNT_W+REF_W)'(REF_FULL);
   wire logic [CNT_W+REF_W-1:0] quot = (per_reg == '0) ? '0 : prod / {{REF_W{1'b0}}, per_reg};
   wire logic [REF_W-1:0] duty_code = quot[REF_W-1:0];
   // steady high for a whole long period counts as full scale
   wire logic steady_high = pin & (per_reg >= CNT_W'(PWM_MAX_PERIOD_CYC));

   always_ff @(posedge clk) begin
      if (srst || !duty_on) begin
         hi_reg <= '0;
         per_reg <= '0;
         ref_reg <= REF_FULL;
         valid_reg <= 1'b0;
      end else if (rise) begin
         ref_reg <= duty_code; // update once per period
         valid_reg <= 1'b1;
         hi_reg <= CNT_W'(1);
         per_reg <= CNT_W'(1);
      end else begin
         hi_reg <= pin ? sat_inc(hi_reg) : hi_reg;
         per_reg <= sat_inc(per_reg);
         if (steady_high) ref_reg <= REF_FULL;
      end
   end

   // ****************************************
   // stored one-wire step
   // ****************************************
   logic [4:0] step_reg;
   // only power reset clears it
   always_ff @(posedge clk) begin
      if (srst) step_reg <= STEP_DEFAULT;
      else if (step_we && state_reg == DMDP_ST_WIRE) step_reg <= step_wdata;
   end

   // ****************************************
   // outputs
   // ****************************************
   logic entry_reg;
   always_ff @(posedge clk) begin
      if (srst) entry_reg <= 1'b0;
      else entry_reg <= (state_reg == DMDP_ST_DETECT) && (state_next == DMDP_ST_WIRE);
   end
   assign wire_entry = entry_reg;
   assign enabled = (state_reg != DMDP_ST_OFF);
   assign one_wire_mode = (state_reg == DMDP_ST_WIRE);
   assign step_reg_out = step_reg;
   assign feedback_node_ref = ref_reg;
   assign ref_valid = valid_reg;
endmodule : dmdp_device
`default_nettype wire

// File: hw/dmdp_host.sv
// dmdp_host: drives the control pin: start-up, one-wire entry, pwm and shutdown
`timescale 1ns/10ps
`default_nettype none
module dmdp_host
   import dmdp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // user commands
   input wire logic start_req,
   input wire logic want_wire,
   input wire logic stop_req,
   input wire logic [dmdp_pkg::CNT_W-1:0] pwm_period,
   input wire logic [dmdp_pkg::CNT_W-1:0] pwm_high,
   // status
   output logic busy,
   output logic running,
   // link
   dmdp_if.host link
);
   import dmdp_pkg::*;

   typedef enum logic [2:0] {DMDP_H_IDLE, DMDP_H_DELAY, DMDP_H_LOW, DMDP_H_HIGH, DMDP_H_PWM,
                             DMDP_H_STOP} dmdp_hstate_t;
   dmdp_hstate_t st_reg, st_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic drive_reg, drive_next;
   // clamp period into the 5..100 kHz range
   wire logic [CNT_W-1:0] per_lo = (pwm_period < CNT_W'(PWM_MIN_PERIOD_CYC)) ? CNT_W'(PWM_MIN_PERIOD_CYC) : pwm_period;
   wire logic [CNT_W-1:0] per_ok = (per_lo > CNT_W'(PWM_MAX_PERIOD_CYC)) ? CNT_W'(PWM_MAX_PERIOD_CYC) : per_lo;
   wire logic cnt_last = (cnt_reg == '0);

   // sequence the pin
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_last ? '0 : cnt_reg - 1'b1;
      drive_next = drive_reg;
      case (st_reg)
         DMDP_H_IDLE: if (start_req) begin
            drive_next = 1'b1; // enabling rise
            st_next = want_wire ? DMDP_H_DELAY : DMDP_H_PWM;
            cnt_next = want_wire ? CNT_W'(DETECT_DELAY_CYC + 4) : per_ok - 1'b1;
         end
         DMDP_H_DELAY: if (cnt_last) begin
            drive_next = 1'b0;
            st_next = DMDP_H_LOW;
            cnt_next = CNT_W'(LOW_QUALIFY_CYC + 4); // over 260 us, within window
         end
         DMDP_H_LOW: if (cnt_last) begin
            drive_next = 1'b1;
            st_next = DMDP_H_HIGH;
         end
         DMDP_H_HIGH: if (stop_req) begin
            drive_next = 1'b0;
            st_next = DMDP_H_STOP;
            cnt_next = CNT_W'(SHUTDOWN_LOW_CYC + 4);
         end
         DMDP_H_PWM: begin
            if (stop_req) begin
               drive_next = 1'b0;
               st_next = DMDP_H_STOP;
               cnt_next = CNT_W'(SHUTDOWN_LOW_CYC + 4);
            end else begin
               if (cnt_last) cnt_next = per_ok - 1'b1;
               // clean logic level, high for the first pwm_high cycles
               drive_next = ((per_ok - cnt_next) <= pwm_high);
            end
         end
         DMDP_H_STOP: if (cnt_last) st_next = DMDP_H_IDLE; // held low 2.5 ms
         default: st_next = DMDP_H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= DMDP_H_IDLE;
         cnt_reg <= '0;
         drive_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         drive_reg <= drive_next;
      end
   end

   assign link.ctrl_out = drive_reg;
   assign link.ctrl_oe = 1'b1;
   assign busy = (st_reg != DMDP_H_IDLE) && (st_reg != DMDP_H_HIGH) && (st_reg != DMDP_H_PWM);
   assign running = (st_reg == DMDP_H_HIGH) || (st_reg == DMDP_H_PWM);
endmodule : dmdp_host
`default_nettype wire

// File: tb/dmdp_assertions.sv
// dmdp_assertions: timing checks on the control pin and device status
`timescale 1ns/10ps
`default_nettype none
module dmdp_assertions
   import dmdp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link and device status
   input wire logic ctrl_pin,
   input wire logic enabled,
   input wire logic one_wire_mode,
   input wire logic wire_entry,
   input wire logic [dmdp_pkg::REF_W-1:0] feedback_node_ref,
   input wire logic ref_valid
);
   import dmdp_pkg::*;

   logic [CNT_W-1:0] low_reg;
   logic [CNT_W-1:0] high_reg;
   logic [CNT_W-1:0] en_reg;
   // run lengths of each pin level and time since enable
   always_ff @(posedge clk) begin
      if (srst) begin
         low_reg <= '0;
         high_reg <= '0;
         en_reg <= '0;
      end else begin
         low_reg <= ctrl_pin ? 17'h0 : low_reg + 17'h1;
         high_reg <= ctrl_pin ? high_reg + 17'h1 : 17'h0;
         en_reg <= enabled ? en_reg + 17'h1 : 17'h0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_entry_pulse;
      wire_entry ##1 !wire_entry;
   endsequence
   a_enable_rise:
      assert property ($rose(ctrl_pin) && !enabled |-> ##3 enabled) else $error("enable late");
   a_wire_timing:
      assert property ($rose(one_wire_mode) |-> en_reg + 4 >= DETECT_DELAY_CYC + LOW_QUALIFY_CYC)
      else $error("one-wire entered too early");
   a_wire_window:
      assert property ($rose(one_wire_mode) |-> en_reg <= DETECT_WINDOW_CYC + 3 && !$past(ctrl_pin, 3))
      else $error("one-wire entered outside window");
   a_entry_pulse:
      assert property ($rose(one_wire_mode) |-> s_entry_pulse) else $error("entry pulse wrong");
   a_mode_held:
      assert property (one_wire_mode && low_reg < SHUTDOWN_LOW_CYC |=> one_wire_mode) else $error("mode lost");
   a_shutdown_low:
      assert property (low_reg == SHUTDOWN_LOW_CYC + 4 |-> !enabled && !one_wire_mode) else $error("no shutdown");
   a_steady_full:
      assert property (enabled && !one_wire_mode && high_reg == 17'd4010 |-> feedback_node_ref == REF_FULL)
      else $error("steady high not full scale");
   a_reset_values:
      assert property ($fell(srst) |-> feedback_node_ref == REF_FULL && !ref_valid && !enabled)
      else $error("reset values wrong");
endmodule : dmdp_assertions
`default_nettype wire

// File: tb/dimming_mode_detect_pwm_ref_tb.sv
// dimming_mode_detect_pwm_ref_tb: host and device joined by the link, self-checking
`timescale 1ns/10ps
`default_nettype none
module dimming_mode_detect_pwm_ref_tb;
   import dmdp_pkg::*;
   logic clk, srst, start_req, want_wire, stop_req, step_we, enabled, one_wire_mode, wire_entry, ref_valid;
   logic busy, running;
   logic [CNT_W-1:0] pwm_period, pwm_high;
   logic [4:0] step_wdata, step_reg_out, stp;
   logic [REF_W-1:0] feedback_node_ref;
   logic [31:0] lfsr_reg;
   int errors, cmp_count, p, h;
   dmdp_if link ();
   dmdp_host dmdp_host_i (.clk(clk), .srst(srst), .start_req(start_req), .want_wire(want_wire),
      .stop_req(stop_req), .pwm_period(pwm_period), .pwm_high(pwm_high), .busy(busy), .running(running),
      .link(link.host));
   dmdp_device dmdp_device_i (.clk(clk), .srst(srst), .link(link.device), .step_we(step_we),
      .step_wdata(step_wdata), .enabled(enabled), .one_wire_mode(one_wire_mode), .wire_entry(wire_entry),
      .step_reg_out(step_reg_out), .feedback_node_ref(feedback_node_ref), .ref_valid(ref_valid));
   dmdp_assertions dmdp_assertions_i (.clk(clk), .srst(srst), .ctrl_pin(link.ctrl_pin), .enabled(enabled),
      .one_wire_mode(one_wire_mode), .wire_entry(wire_entry), .feedback_node_ref(feedback_node_ref),
      .ref_valid(ref_valid));
   // free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   function automatic logic [REF_W-1:0] exp_ref(input int hi, input int per);
      return REF_W'((hi * 1023) / per);
   endfunction : exp_ref
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : cyc
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_code(input logic [REF_W-1:0] got, input logic [REF_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_code
   task automatic start(input logic wire_mode);
      while (busy !== 1'b0) cyc(1); // host takes a start only once idle again
      want_wire = wire_mode;
      start_req = 1'b1;
      cyc(1);
      start_req = 1'b0;
   endtask : start
   task automatic results();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   // watchdog against a hang
   initial begin
      #(95000 * CLK_NS);
      errors++;
      results();
   end
   // main sequence
   initial begin
      errors = 0;
      cmp_count = 0;
      lfsr_reg = lfsr_next(32'h66551f0f);
      {srst, start_req, want_wire, stop_req, step_we} = 5'h10;
      step_wdata = 5'h00;
      pwm_period = 17'h00fa0;
      pwm_high = 17'h00fa0;
      cyc(10);
      srst = 1'b0;
      chk_code(feedback_node_ref, REF_FULL);
      chk_code(10'(step_reg_out), 10'(STEP_DEFAULT));
      // entry pattern, then store a random step
      start(1'b1);
      for (int i = 0; i < 8000 && one_wire_mode !== 1'b1; i++) cyc(1);
      chk_bit(one_wire_mode, 1'b1);
      stp = lfsr_reg[4:0];
      step_wdata = stp;
      step_we = 1'b1;
      cyc(1);
      step_we = 1'b0;
      cyc(2);
      chk_code(10'(step_reg_out), 10'(stp));
      // long low: mode held until shutdown, step survives
      stop_req = 1'b1;
      cyc(SHUTDOWN_LOW_CYC - 100);
      chk_bit(one_wire_mode, 1'b1);
      for (int i = 0; i < 200 && enabled !== 1'b0; i++) cyc(1);
      stop_req = 1'b0;
      chk_bit(enabled, 1'b0);
      chk_code(10'(step_reg_out), 10'(stp));
      // restart without pattern: steady high, step writes refused
      start(1'b0);
      step_wdata = ~stp;
      step_we = 1'b1;
      cyc(1);
      step_we = 1'b0;
      cyc(6000);
      chk_bit(enabled, 1'b1);
      chk_bit(running, 1'b1);
      chk_bit(one_wire_mode, 1'b0);
      chk_code(feedback_node_ref, REF_FULL);
      chk_code(10'(step_reg_out), 10'(stp));
      // power reset clears the step, then random duty
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      chk_code(10'(step_reg_out), 10'(STEP_DEFAULT));
      lfsr_reg = lfsr_next(lfsr_reg);
      p = 200 + int'(lfsr_reg[15:0]) % 3801;
      h = 1 + int'(lfsr_reg[31:16]) % (p - 1);
      pwm_period = CNT_W'(p);
      pwm_high = CNT_W'(h);
      start(1'b0);
      cyc(DETECT_WINDOW_CYC + 2000);
      chk_bit(one_wire_mode, 1'b0);
      chk_bit(ref_valid, 1'b1);
      chk_code(feedback_node_ref, exp_ref(h, p));
      // pin held high for a whole long period brings full scale back
      pwm_high = 17'h1ffff;
      cyc(4100);
      chk_code(feedback_node_ref, REF_FULL);
      results();
   end
endmodule : dimming_mode_detect_pwm_ref_tb
`default_nettype wire
